// ### logic/addr_gen_pkg.sv
// constants, types and helper functions of the data address generator
// Function
// - byte load into a working register writes the low byte, keeps the high byte
// - sign extend copies bit 7 of a register into its upper byte
// - zero fill clears the upper byte of a register
// - direct instructions reach 0x0000..0x1fff through a 13-bit field
// - move direct uses a 16-bit field and reaches all of X space
// - register 15 is the stack pointer, next free word, growing upward
// - pop decrements before the access, push increments after it
// - call pushes the pc high word with its upper byte zero
// - exception push puts the status low byte in the pushed high word's upper byte
// - stack limit has no reset value and its bit 0 is always zero
// - stack pointer addresses checked against limit; push at limit passes, next traps
// - stack pointer address below 0x0800 raises a stack error trap
// - two address generators; Y serves only word reads for multiply-accumulate
// - linear, modulo and bit-reversed modes; bit-reversed only in data space
// - file register ops use a 13-bit field with register 0 as default
// - three-operand ops: first operand register direct; second register, memory or 5-bit literal
// - post-modify uses then adjusts the pointer; pre-modify adjusts then uses
// - offset modes add a base register or a literal to the pointer
// - multiply-accumulate class accesses are word sized only
package addr_gen_pkg;
   // ---------------------------------------------------------------
   // register map (byte offsets)
   // ---------------------------------------------------------------
   localparam logic [7:0] ofs_stack_limit = 8'h00;
   localparam logic [7:0] ofs_mod_start = 8'h04;
   localparam logic [7:0] ofs_mod_end = 8'h08;
   localparam logic [7:0] ofs_bitrev_mod = 8'h0c;
   localparam logic [7:0] ofs_last_ea = 8'h10;
   localparam logic [7:0] ofs_trap_count = 8'h14;
   localparam logic [15:0] mod_start_rst = 16'h0000;
   localparam logic [15:0] mod_end_rst = 16'hffff;
   localparam logic [15:0] bitrev_mod_rst = 16'h0000;
   // ---------------------------------------------------------------
   // address space constants
   // ---------------------------------------------------------------
   localparam logic [15:0] sfr_floor = 16'h0800;
   localparam logic [15:0] word_step = 16'h0002;
   localparam logic [15:0] byte_step = 16'h0001;
   localparam logic [3:0] sp_index = 4'hf;
   localparam logic [3:0] default_working_register_index = 4'h0;
   localparam logic [1:0] htrans_nonseq = 2'h2;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      op_load, op_sign_ext, op_zero_fill, op_file_dir, op_mov_dir, op_indirect,
      op_three, op_push, op_pop, op_call_push, op_exc_push
   } op_type;
   typedef enum logic [2:0] {
      ind_plain, ind_post_inc, ind_post_dec, ind_pre_inc, ind_pre_dec,
      ind_reg_off, ind_lit_off
   } ind_type;
   typedef enum logic [1:0] {am_linear, am_modulo, am_bitrev} am_type;
   typedef enum logic [1:0] {src2_reg, src2_mem, src2_lit5} src2_type;
   typedef struct packed {
      op_type code;
      logic [3:0] wn;
      ind_type ind;
      am_type am;
      src2_type src2;
      logic [15:0] lit;
      logic byte_sz;
      logic store;
      logic agu_y;
      logic prog;
      logic [23:0] pc;
      logic [7:0] status_low_byte;
   } op_bundle_type;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] rev16(input logic [15:0] v);
      for (int i = 0; i < 16; i++) begin
         rev16[i] = v[15-i];
      end
   endfunction : rev16

   // pointer adjust for post/pre modify, honouring the addressing mode
   function automatic logic [15:0] adjust(input logic [15:0] p, input logic up,
      input logic [15:0] st, input am_type am, input logic prog,
      input logic [15:0] ms, input logic [15:0] me, input logic [15:0] br);
      logic [15:0] raw;
      logic [15:0] len;
      raw = up ? p + st : p - st;
      len = me - ms + 16'h0001;
      adjust = raw;
      if (am == am_bitrev && !prog && up) begin
         adjust = rev16(rev16(p) + rev16(br));
      end else if (am == am_modulo) begin
         if (raw > me) begin
            adjust = raw - len;
         end else if (raw < ms) begin
            adjust = raw + len;
         end
      end
   endfunction : adjust
endpackage : addr_gen_pkg

// ### logic/default_working_register_if.sv
// port bundle between the address generator and its working register file
`timescale 1ns/100ps
interface default_working_register_if;
   logic [3:0] ra;
   logic [3:0] rb;
   logic [15:0] rda;
   logic [15:0] rdb;
   logic we;
   logic [3:0] wa;
   logic [15:0] wd;
   modport ctrl(output ra, output rb, output we, output wa, output wd,
      input rda, input rdb);
   modport mem(input ra, input rb, input we, input wa, input wd,
      output rda, output rdb);
endinterface : default_working_register_if

// ### logic/default_working_register_file.sv
// sixteen working registers, two registered read ports and one write port
`timescale 1ns/100ps
module default_working_register_file (
   input wire logic clk_i,
   default_working_register_if.mem rf
);
   logic [15:0] regs_q [0:15];

   // read returns the value before a same-edge write; the sequencer never relies on that
   always_ff @(posedge clk_i) begin
      if (rf.we) begin
         regs_q[rf.wa] <= rf.wd;
      end
      rf.rda <= regs_q[rf.ra];
      rf.rdb <= regs_q[rf.rb];
   end
endmodule : default_working_register_file

// ### logic/addr_gen.sv
// data address generator with software stack limit checking and AHB-Lite registers
`timescale 1ns/100ps
module addr_gen
   import addr_gen_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic op_valid_i,
   input wire op_type op_code_i,
   input wire logic [3:0] op_wn_i,
   input wire logic [3:0] op_wb_i,
   input wire ind_type op_ind_i,
   input wire am_type op_am_i,
   input wire src2_type op_src2_i,
   input wire logic [15:0] op_lit_i,
   input wire logic op_byte_i,
   input wire logic op_store_i,
   input wire logic op_agu_y_i,
   input wire logic op_prog_i,
   input wire logic [23:0] pc_i,
   input wire logic [7:0] status_low_byte_i,
   output logic op_ready_o,
   output logic mem_valid_o,
   output logic mem_we_o,
   output logic mem_byte_o,
   output logic mem_prog_o,
   output logic mem_y_o,
   output logic [15:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic [15:0] opa_o,
   output logic [15:0] opb_o,
   output logic stack_trap_o
);
   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   default_working_register_if rf ();

   default_working_register_file u_default_working_register_file (
      .clk_i(clk_i),
      .rf(rf.mem)
   );

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic ap_valid_r, ap_valid_nxt;
   logic ap_write_r, ap_write_nxt;
   logic [7:0] ap_addr_r, ap_addr_nxt;
   logic [15:0] stack_limit_r, stack_limit_nxt;
   logic [15:0] mod_start_r, mod_start_nxt;
   logic [15:0] mod_end_r, mod_end_nxt;
   logic [15:0] bitrev_r, bitrev_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic [15:0] last_ea_r, last_ea_nxt;
   logic [15:0] trap_count_r, trap_count_nxt;
   logic take_ap;

   assign take_ap = hsel_i && htrans_i == htrans_nonseq && hready_i;

   always_comb begin
      ap_valid_nxt = take_ap;
      ap_write_nxt = hwrite_i;
      ap_addr_nxt = haddr_i[7:0];
      stack_limit_nxt = stack_limit_r;
      mod_start_nxt = mod_start_r;
      mod_end_nxt = mod_end_r;
      bitrev_nxt = bitrev_r;
      if (ap_valid_r && ap_write_r) begin
         unique case (ap_addr_r)
            ofs_stack_limit: stack_limit_nxt = {hwdata_i[15:1], 1'b0};
            ofs_mod_start: mod_start_nxt = hwdata_i[15:0];
            ofs_mod_end: mod_end_nxt = hwdata_i[15:0];
            ofs_bitrev_mod: bitrev_nxt = hwdata_i[15:0];
            default: ;
         endcase
      end
      // read data built from next values so a read right after a write sees it
      hrdata_nxt = 32'h0000_0000;
      if (take_ap && !hwrite_i) begin
         unique case (haddr_i[7:0])
            ofs_stack_limit: hrdata_nxt = {16'h0000, stack_limit_nxt[15:1], 1'b0};
            ofs_mod_start: hrdata_nxt = {16'h0000, mod_start_nxt};
            ofs_mod_end: hrdata_nxt = {16'h0000, mod_end_nxt};
            ofs_bitrev_mod: hrdata_nxt = {16'h0000, bitrev_nxt};
            ofs_last_ea: hrdata_nxt = {16'h0000, last_ea_r};
            ofs_trap_count: hrdata_nxt = {16'h0000, trap_count_r};
            default: hrdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // stack limit is deliberately left without reset
   always_ff @(posedge clk_i) begin
      stack_limit_r <= stack_limit_nxt;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r <= 8'h00;
         mod_start_r <= mod_start_rst;
         mod_end_r <= mod_end_rst;
         bitrev_r <= bitrev_mod_rst;
         hrdata_r <= 32'h0000_0000;
         hreadyout_o <= 1'b0;
         hresp_o <= 1'b0;
      end else begin
         ap_valid_r <= ap_valid_nxt;
         ap_write_r <= ap_write_nxt;
         ap_addr_r <= ap_addr_nxt;
         mod_start_r <= mod_start_nxt;
         mod_end_r <= mod_end_nxt;
         bitrev_r <= bitrev_nxt;
         hrdata_r <= hrdata_nxt;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   assign hrdata_o = hrdata_r;

   // ---------------------------------------------------------------
   // operation sequencer
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {st_idle, st_exec, st_push_hi} state_type;

   state_type state_r, state_nxt;
   op_bundle_type op_r, op_nxt;
   logic [15:0] sp_hold_r, sp_hold_nxt;
   logic op_ready_nxt;
   logic mem_valid_nxt, mem_we_nxt, mem_byte_nxt, mem_prog_nxt, mem_y_nxt;
   logic [15:0] mem_addr_nxt, mem_wdata_nxt, opa_nxt, opb_nxt;
   logic stack_trap_nxt;
   logic is_stack_op;
   logic [15:0] p, b, st, ea, newp;
   logic word_only, eff_byte, eff_we, chk_sp, ptr_we;

   assign is_stack_op = op_code_i inside {op_push, op_pop, op_call_push, op_exc_push};

   always_comb begin
      // register reads issued while idle land in st_exec
      rf.ra = is_stack_op ? sp_index : op_wn_i;
      rf.rb = op_code_i == op_push ? op_wn_i :
              op_code_i == op_file_dir ? default_working_register_index : op_wb_i;
      rf.we = 1'b0;
      rf.wa = op_r.wn;
      rf.wd = 16'h0000;
      state_nxt = state_r;
      op_nxt = op_r;
      sp_hold_nxt = sp_hold_r;
      mem_valid_nxt = 1'b0;
      mem_we_nxt = 1'b0;
      mem_byte_nxt = 1'b0;
      mem_prog_nxt = 1'b0;
      mem_y_nxt = 1'b0;
      mem_addr_nxt = mem_addr_o;
      mem_wdata_nxt = mem_wdata_o;
      opa_nxt = opa_o;
      opb_nxt = opb_o;
      stack_trap_nxt = 1'b0;
      last_ea_nxt = last_ea_r;
      p = rf.rda;
      b = rf.rdb;
      // multiply-accumulate class through Y is word-only and read-only
      word_only = op_r.agu_y;
      eff_byte = op_r.byte_sz && !word_only;
      eff_we = op_r.store && !word_only;
      st = eff_byte ? byte_step : word_step;
      ea = p;
      newp = p;
      ptr_we = 1'b0;
      unique case (op_r.ind)
         ind_plain: ea = p;
         ind_post_inc: begin
            newp = adjust(p, 1'b1, st, op_r.am, op_r.prog, mod_start_r, mod_end_r,
               bitrev_r);
            ptr_we = 1'b1;
         end
         ind_post_dec: begin
            newp = adjust(p, 1'b0, st, op_r.am, op_r.prog, mod_start_r, mod_end_r,
               bitrev_r);
            ptr_we = 1'b1;
         end
         ind_pre_inc: begin
            newp = adjust(p, 1'b1, st, op_r.am, op_r.prog, mod_start_r, mod_end_r,
               bitrev_r);
            ea = newp;
            ptr_we = 1'b1;
         end
         ind_pre_dec: begin
            newp = adjust(p, 1'b0, st, op_r.am, op_r.prog, mod_start_r, mod_end_r,
               bitrev_r);
            ea = newp;
            ptr_we = 1'b1;
         end
         ind_reg_off: ea = p + b;
         ind_lit_off: ea = p + op_r.lit;
         default: ea = p;
      endcase
      chk_sp = op_r.wn == sp_index;
      unique case (state_r)
         st_idle: begin
            if (op_valid_i) begin
               op_nxt.code = op_code_i;
               op_nxt.wn = is_stack_op ? sp_index : op_wn_i;
               op_nxt.ind = op_ind_i;
               op_nxt.am = op_am_i;
               op_nxt.src2 = op_src2_i;
               op_nxt.lit = op_lit_i;
               op_nxt.byte_sz = op_byte_i;
               op_nxt.store = op_store_i;
               op_nxt.agu_y = op_agu_y_i;
               op_nxt.prog = op_prog_i;
               op_nxt.pc = pc_i;
               op_nxt.status_low_byte = status_low_byte_i;
               state_nxt = st_exec;
            end
         end
         st_exec: begin
            state_nxt = st_idle;
            chk_sp = 1'b0;
            unique case (op_r.code)
               op_load: begin
                  rf.we = 1'b1;
                  rf.wd = op_r.byte_sz ? {p[15:8], op_r.lit[7:0]} : op_r.lit;
               end
               op_sign_ext: begin
                  rf.we = 1'b1;
                  rf.wd = {{8{p[7]}}, p[7:0]};
               end
               op_zero_fill: begin
                  rf.we = 1'b1;
                  rf.wd = {8'h00, p[7:0]};
               end
               op_file_dir, op_mov_dir: begin
                  mem_valid_nxt = 1'b1;
                  mem_we_nxt = op_r.store;
                  mem_byte_nxt = op_r.byte_sz;
                  mem_wdata_nxt = b;
                  mem_addr_nxt = op_r.code == op_file_dir ?
                     {3'b000, op_r.lit[12:0]} : op_r.lit;
               end
               op_indirect, op_three: begin
                  opa_nxt = b;
                  opb_nxt = op_r.src2 == src2_lit5 ? {11'h000, op_r.lit[4:0]} : p;
                  if (op_r.code == op_indirect || op_r.src2 == src2_mem) begin
                     mem_valid_nxt = 1'b1;
                     mem_we_nxt = op_r.code == op_indirect && eff_we;
                     mem_byte_nxt = eff_byte;
                     mem_prog_nxt = op_r.prog;
                     mem_y_nxt = op_r.agu_y;
                     mem_addr_nxt = ea;
                     mem_wdata_nxt = b;
                     chk_sp = op_r.wn == sp_index;
                     rf.we = ptr_we;
                     rf.wd = newp;
                  end
               end
               op_push: begin
                  mem_valid_nxt = 1'b1;
                  mem_we_nxt = 1'b1;
                  mem_addr_nxt = p;
                  mem_wdata_nxt = b;
                  ea = p;
                  chk_sp = 1'b1;
                  rf.we = 1'b1;
                  rf.wd = p + word_step;
               end
               op_pop: begin
                  ea = p - word_step;
                  mem_valid_nxt = 1'b1;
                  mem_addr_nxt = ea;
                  chk_sp = 1'b1;
                  rf.we = 1'b1;
                  rf.wd = ea;
               end
               op_call_push, op_exc_push: begin
                  mem_valid_nxt = 1'b1;
                  mem_we_nxt = 1'b1;
                  mem_addr_nxt = p;
                  mem_wdata_nxt = op_r.pc[15:0];
                  ea = p;
                  chk_sp = 1'b1;
                  sp_hold_nxt = p + word_step;
                  state_nxt = st_push_hi;
               end
               default: ;
            endcase
         end
         st_push_hi: begin
            state_nxt = st_idle;
            ea = sp_hold_r;
            chk_sp = 1'b1;
            mem_valid_nxt = 1'b1;
            mem_we_nxt = 1'b1;
            mem_addr_nxt = sp_hold_r;
            mem_wdata_nxt = op_r.code == op_exc_push ?
               {op_r.status_low_byte, op_r.pc[23:16]} : {8'h00, op_r.pc[23:16]};
            rf.we = 1'b1;
            rf.wa = sp_index;
            rf.wd = sp_hold_r + word_step;
         end
         default: state_nxt = st_idle;
      endcase
      if (state_r == st_idle) begin
         chk_sp = 1'b0;
      end
      // push landing exactly on the limit passes; beyond it or into sfr space traps
      if (chk_sp && (ea > stack_limit_r || ea < sfr_floor)) begin
         stack_trap_nxt = 1'b1;
      end
      if (mem_valid_nxt) begin
         last_ea_nxt = mem_addr_nxt;
      end
      trap_count_nxt = trap_count_r + {15'h0000, stack_trap_nxt};
      op_ready_nxt = state_nxt == st_idle;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= st_idle;
         op_r <= '0;
         sp_hold_r <= 16'h0000;
         last_ea_r <= 16'h0000;
         trap_count_r <= 16'h0000;
         op_ready_o <= 1'b0;
         mem_valid_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_byte_o <= 1'b0;
         mem_prog_o <= 1'b0;
         mem_y_o <= 1'b0;
         mem_addr_o <= 16'h0000;
         mem_wdata_o <= 16'h0000;
         opa_o <= 16'h0000;
         opb_o <= 16'h0000;
         stack_trap_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         sp_hold_r <= sp_hold_nxt;
         last_ea_r <= last_ea_nxt;
         trap_count_r <= trap_count_nxt;
         op_ready_o <= op_ready_nxt;
         mem_valid_o <= mem_valid_nxt;
         mem_we_o <= mem_we_nxt;
         mem_byte_o <= mem_byte_nxt;
         mem_prog_o <= mem_prog_nxt;
         mem_y_o <= mem_y_nxt;
         mem_addr_o <= mem_addr_nxt;
         mem_wdata_o <= mem_wdata_nxt;
         opa_o <= opa_nxt;
         opb_o <= opb_nxt;
         stack_trap_o <= stack_trap_nxt;
      end
   end
endmodule : addr_gen

// ### tb/addr_gen_checker.sv
// concurrent checks on the address generator ports
`timescale 1ns/100ps
module addr_gen_checker
   import addr_gen_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic op_valid_i,
   input wire op_type op_code_i,
   input wire logic [15:0] op_lit_i,
   input wire logic op_agu_y_i,
   input wire logic [23:0] pc_i,
   input wire logic [7:0] status_low_byte_i,
   input wire logic op_ready_o,
   input wire logic mem_valid_o,
   input wire logic mem_we_o,
   input wire logic mem_byte_o,
   input wire logic mem_y_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [15:0] mem_wdata_o,
   input wire logic stack_trap_o
);
   // ---------------------------------------------------------------
   // operation accepted
   // ---------------------------------------------------------------
   logic take;
   assign take = op_valid_i && op_ready_o;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   property p_trap_access;
      stack_trap_o |-> mem_valid_o;
   endproperty
   a_trap_access: assert property (p_trap_access) else $error("trap without access");
   property p_push_store;
      take && op_code_i == op_push |-> ##2 mem_valid_o && mem_we_o && !mem_y_o;
   endproperty
   a_push_store: assert property (p_push_store) else $error("push not stored");
   property p_pop_read;
      take && op_code_i == op_pop |-> ##2 mem_valid_o && !mem_we_o;
   endproperty
   a_pop_read: assert property (p_pop_read) else $error("pop not a read");
   property p_call_frame;
      take && op_code_i == op_call_push |-> ##2 mem_wdata_o == $past(pc_i[15:0], 2)
         ##1 mem_valid_o && mem_wdata_o == {8'h00, $past(pc_i[23:16], 3)}
         && mem_addr_o == $past(mem_addr_o) + word_step;
   endproperty
   a_call_frame: assert property (p_call_frame) else $error("bad call frame");
   property p_exc_frame;
      take && op_code_i == op_exc_push |-> ##3 mem_valid_o
         && mem_wdata_o == {$past(status_low_byte_i, 3), $past(pc_i[23:16], 3)};
   endproperty
   a_exc_frame: assert property (p_exc_frame) else $error("bad exception frame");
   property p_underflow;
      take && op_code_i == op_push ##2 mem_addr_o < sfr_floor |-> stack_trap_o;
   endproperty
   a_underflow: assert property (p_underflow) else $error("missed underflow");
   property p_mac_word;
      take && op_agu_y_i |-> ##2 mem_valid_o && mem_y_o && !mem_byte_o && !mem_we_o;
   endproperty
   a_mac_word: assert property (p_mac_word) else $error("y access not word read");
   property p_mov_addr;
      take && op_code_i == op_mov_dir |-> ##2 mem_valid_o && mem_addr_o == $past(op_lit_i, 2);
   endproperty
   a_mov_addr: assert property (p_mov_addr) else $error("bad move address");
   property p_file_addr;
      take && op_code_i == op_file_dir |-> ##2 mem_addr_o == {3'h0, $past(op_lit_i[12:0], 2)};
   endproperty
   a_file_addr: assert property (p_file_addr) else $error("bad file address");
endmodule : addr_gen_checker

bind addr_gen addr_gen_checker u_checker (.clk_i(clk_i), .srst_i(srst_i),
   .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_lit_i(op_lit_i),
   .op_agu_y_i(op_agu_y_i), .pc_i(pc_i), .status_low_byte_i(status_low_byte_i),
   .op_ready_o(op_ready_o), .mem_valid_o(mem_valid_o), .mem_we_o(mem_we_o),
   .mem_byte_o(mem_byte_o), .mem_y_o(mem_y_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .stack_trap_o(stack_trap_o));

// ### tb/data_mem_model.sv
// data memory model that keeps every word the generator writes
`timescale 1ns/100ps
module data_mem_model (
   input wire logic clk_i,
   input wire logic mem_valid_i,
   input wire logic mem_we_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [15:0] mem_wdata_i
);
   logic [15:0] mem [logic [15:0]];
   // reads return nothing: the generator has no read data input
   always @(posedge clk_i) begin
      if (mem_valid_i === 1'b1 && mem_we_i === 1'b1) begin
         mem[mem_addr_i] = mem_wdata_i;
      end
   end
endmodule : data_mem_model

// ### tb/test_address_gen_stack_limit.sv
// self-checking bench for the address generator and stack limit checker
`timescale 1ns/100ps
module test_address_gen_stack_limit;
   import addr_gen_pkg::*;
   logic clk_i, srst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
   logic [1:0] htrans_i;
   logic [2:0] hsize_i;
   logic op_valid_i, op_byte_i, op_store_i, op_agu_y_i, op_prog_i, op_ready_o;
   op_type op_code_i;
   ind_type op_ind_i;
   am_type op_am_i;
   src2_type op_src2_i;
   logic [3:0] op_wn_i, op_wb_i;
   logic [15:0] op_lit_i, mem_addr_o, mem_wdata_o, opa_o, opb_o, v;
   logic [23:0] pc_i, pc;
   logic [7:0] status_low_byte_i, b, sl;
   logic mem_valid_o, mem_we_o, mem_byte_o, mem_prog_o, mem_y_o, stack_trap_o;
   logic [71:0] expq[$];
   logic [71:0] e;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   wire logic [35:0] obs = {stack_trap_o, mem_we_o, mem_byte_o, mem_y_o, mem_addr_o, mem_wdata_o};
   assign hready_i = hreadyout_o;
   addr_gen dut (.*);
   data_mem_model pm (.clk_i(clk_i), .mem_valid_i(mem_valid_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   // flags are trap, write, byte, y; write data only matters on writes
   task automatic note(input logic [3:0] f, input logic [15:0] a, input logic [15:0] d);
      expq.push_back({20'hfffff, f[2] ? 16'hffff : 16'h0000, f, a, d});
   endtask : note
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      hwrite_i <= w;
      haddr_i <= {24'h0, a};
      htrans_i <= htrans_nonseq;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      r = hrdata_o;
   endtask : bus
   task automatic op(input op_type c, input logic [3:0] wn, input logic [15:0] lit,
         input ind_type ind = ind_plain, input logic y = 1'b0, input logic by = 1'b0);
      @(posedge clk_i);
      op_valid_i <= 1'b1;
      op_code_i <= c;
      op_wn_i <= wn;
      op_lit_i <= lit;
      op_ind_i <= ind;
      op_agu_y_i <= y;
      op_byte_i <= by;
      op_store_i <= y || c inside {op_push, op_call_push, op_exc_push};
      do @(posedge clk_i); while (op_ready_o !== 1'b1);
      op_valid_i <= 1'b0;
   endtask : op
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         summarize();
      end
      if (mem_valid_o === 1'b1) begin
         e = (expq.size() > 0) ? expq.pop_front() : '1;
         chk(obs & e[71:36], e[35:0]);
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {hsel_i, hwrite_i, haddr_i, htrans_i, hwdata_i, op_valid_i, op_wn_i, op_wb_i} = '0;
      {op_lit_i, op_byte_i, op_store_i, op_agu_y_i, op_prog_i, pc_i, status_low_byte_i} = '0;
      hsize_i = 3'h2;
      op_code_i = op_load;
      op_ind_i = ind_plain;
      op_am_i = am_linear;
      op_src2_i = src2_reg;
      srst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      void'($urandom(32'h2579));
      bus(1'b0, 8'h18, 32'h0);
      chk(r, 32'h0);
      bus(1'b1, ofs_stack_limit, 32'h1fff);
      bus(1'b0, ofs_stack_limit, 32'h0);
      chk(r, 32'h1ffe);
      v = 16'($urandom());
      op(op_load, 4'h3, v);
      op(op_load, sp_index, 16'h1ffc);
      note(4'b0100, 16'h1ffc, v); op(op_push, 4'h3, 0);
      note(4'b0100, 16'h1ffe, v); op(op_push, 4'h3, 0);
      note(4'b0000, 16'h1ffe, 0); op(op_pop, 4'h4, 0);
      note(4'b0100, 16'h1ffe, v); op(op_push, 4'h3, 0);
      note(4'b1100, 16'h2000, v); op(op_push, 4'h3, 0);
      op(op_load, sp_index, 16'h0800);
      note(4'b0100, 16'h0800, v); op(op_push, 4'h3, 0);
      op(op_load, sp_index, 16'h07fe);
      note(4'b1100, 16'h07fe, v); op(op_push, 4'h3, 0);
      op(op_load, sp_index, 16'h1000);
      b = {1'b1, 7'($urandom())};
      op(op_load, 4'h3, {8'h00, b}, ind_plain, 1'b0, 1'b1);
      note(4'b0100, 16'h1000, {v[15:8], b}); op(op_push, 4'h3, 0);
      op(op_sign_ext, 4'h3, 0);
      note(4'b0100, 16'h1002, {8'hff, b}); op(op_push, 4'h3, 0);
      op(op_zero_fill, 4'h3, 0);
      note(4'b0100, 16'h1004, {8'h00, b}); op(op_push, 4'h3, 0);
      pc = 24'($urandom());
      sl = 8'($urandom());
      pc_i <= pc;
      status_low_byte_i <= sl;
      note(4'b0100, 16'h1006, pc[15:0]);
      note(4'b0100, 16'h1008, {8'h00, pc[23:16]}); op(op_call_push, 0, 0);
      note(4'b0100, 16'h100a, pc[15:0]);
      note(4'b0100, 16'h100c, {sl, pc[23:16]}); op(op_exc_push, 0, 0);
      v = 16'($urandom());
      note(4'b0000, v, 0); op(op_mov_dir, 4'h1, v);
      note(4'b0000, v & 16'h1fff, 0); op(op_file_dir, 4'h0, v);
      op(op_load, 4'h2, 16'h1100);
      note(4'b0000, 16'h1100, 0); op(op_indirect, 4'h2, 0, ind_post_inc);
      note(4'b0000, 16'h1100, 0); op(op_indirect, 4'h2, 0, ind_pre_dec);
      note(4'b0000, 16'h1104, 0); op(op_indirect, 4'h2, 16'h0004, ind_lit_off);
      note(4'b0001, 16'h1100, 0); op(op_indirect, 4'h2, 0, ind_plain, 1'b1, 1'b1);
      op(op_load, 4'h0, v);
      op_src2_i <= src2_lit5;
      op(op_three, 4'h2, 16'h00f3);
      repeat (2) @(posedge clk_i);
      chk({opa_o, opb_o}, {v, 16'h0013});
      repeat (6) @(posedge clk_i);
      chk(pm.mem[16'h1006], pc[15:0]);
      bus(1'b0, ofs_trap_count, 32'h0);
      chk(r, 32'h2);
      chk(expq.size(), 0);
      summarize();
   end
endmodule : test_address_gen_stack_limit
